// [hw/ofu_pkg.sv]
package ofu_pkg;

	// ****************************************
	// Operand sizes and load/store codes
	// ****************************************
	typedef enum logic [2:0] {
		OFU_SZ_8,
		OFU_SZ_16,
		OFU_SZ_32,
		OFU_SZ_64,
		OFU_SZ_128
	} ofu_size_t;

	// ****************************************
	// Single-precision layout
	// ****************************************
	localparam int SGL_SIGN_POS  = 31;
	localparam int SGL_EXP_HI    = 30;
	localparam int SGL_EXP_LO    = 23;
	localparam int SGL_FRAC_HI   = 22;
	localparam int SGL_EXP_W     = 8;
	localparam int SGL_FRAC_W    = 23;
	localparam logic [7:0] SGL_EXP_MAX = 8'hff;
	localparam logic [10:0] SGL_BIAS   = 11'h07f;

	// ****************************************
	// Double-precision layout
	// ****************************************
	localparam int DBL_SIGN_POS  = 63;
	localparam int DBL_EXP_HI    = 62;
	localparam int DBL_EXP_LO    = 52;
	localparam int DBL_FRAC_HI   = 51;
	localparam int DBL_EXP_W     = 11;
	localparam int DBL_FRAC_W    = 52;
	localparam logic [10:0] DBL_EXP_MAX = 11'h7ff;
	localparam logic [10:0] DBL_BIAS    = 11'h3ff;

	// ****************************************
	// Register pair split
	// ****************************************
	localparam int PAIR_LO_HI = 31;
	localparam int PAIR_HI_LO = 32;

	// ****************************************
	// Pixel formats
	// ****************************************
	typedef enum logic [1:0] {
		OFU_PIX_8   = 2'h0,
		OFU_PIX_16  = 2'h1,
		OFU_PIX_32  = 2'h2,
		OFU_PIX_UND = 2'h3
	} ofu_pix_t;

	localparam int PIX16_F1_W = 6;
	localparam int PIX16_F2_W = 6;
	localparam int PIX16_F3_W = 4;
	localparam int PIX32_F_W  = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [63:0] RST_WORD = 64'h0000_0000_0000_0000;

endpackage : ofu_pkg

// [hw/ofu_fp_class.sv]
`timescale 1ns/1ps
module ofu_fp_class (
	input  wire logic        i_dbl,
	input  wire logic [63:0] i_op,
	output logic             o_trap,
	output logic             o_zero,
	output logic             o_sign,
	output logic [11:0]      o_unb_exp,
	output logic [52:0]      o_mant
);
	import ofu_pkg::*;

	logic [10:0] exp_w;
	logic        frac_nz;
	logic        exp_max;

	// ****************************************
	// Field decode
	// ****************************************
	always_comb begin
		if (i_dbl) begin
			o_sign  = i_op[DBL_SIGN_POS];
			exp_w   = i_op[DBL_EXP_HI:DBL_EXP_LO];
			frac_nz = |i_op[DBL_FRAC_HI:0];
			exp_max = (exp_w == DBL_EXP_MAX);
			o_mant    = {1'b1, i_op[DBL_FRAC_HI:0]};
			o_unb_exp = 12'({1'b0, exp_w} - {1'b0, DBL_BIAS});
		end else begin
			o_sign  = i_op[SGL_SIGN_POS];
			exp_w   = {3'h0, i_op[SGL_EXP_HI:SGL_EXP_LO]};
			frac_nz = |i_op[SGL_FRAC_HI:0];
			exp_max = (exp_w[7:0] == SGL_EXP_MAX);
			o_mant    = {1'b1, i_op[SGL_FRAC_HI:0], 29'h0000_0000};
			o_unb_exp = 12'({1'b0, exp_w} - {1'b0, SGL_BIAS});
		end
		o_trap = exp_max | ((exp_w == 11'h000) & frac_nz);
		o_zero = (exp_w == 11'h000) & ~frac_nz;
		if (o_zero) begin
			o_mant = 53'h0_0000_0000_0000;
		end
	end

endmodule : ofu_fp_class

// [hw/ofu_pix_store.sv]
`timescale 1ns/1ps
module ofu_pix_store (
	input  wire logic [1:0] i_pixel_size_field,
	input  wire logic [7:0] i_pixel_write_mask,
	output logic      [7:0] o_byte_en,
	output logic            o_size_bad
);
	import ofu_pkg::*;

	// ****************************************
	// Mask to byte lanes
	// ****************************************
	always_comb begin
		o_size_bad = 1'b0;
		o_byte_en  = 8'h00;
		case (ofu_pix_t'(i_pixel_size_field))
			OFU_PIX_8: begin
				o_byte_en = i_pixel_write_mask;
			end
			OFU_PIX_16: begin
				for (int k = 0; k < 4; k++) begin
					o_byte_en[2*k +: 2] = {2{i_pixel_write_mask[k]}};
				end
			end
			OFU_PIX_32: begin
				for (int k = 0; k < 2; k++) begin
					o_byte_en[4*k +: 4] = {4{i_pixel_write_mask[k]}};
				end
			end
			default: begin
				o_size_bad = 1'b1;
			end
		endcase
	end

endmodule : ofu_pix_store

// [hw/ofu_top.sv]
// Behaviour
// - Bit zero is the least significant bit in every format
// - Load/store sizes 8, 16, 32, 64 and 128 bits
// - Integers 32-bit two's complement; ordinals 32-bit unsigned
// - 64-bit add and subtract, signed and unsigned
// - 8/16-bit loads sign-extend to 32 bits
// - 8/16-bit stores write only low register bits
// - Single: sign 31, exponent 30..23, fraction 22..0
// - Single normal: implied one, bias 127
// - Double: sign 63, exponent 62..52, fraction 51..0
// - Double normal: implied one, bias 1023
// - All-ones exponent or denormal raises source-exception trap
// - Zero exponent and fraction is signed zero, no trap
// - Results only normals or signed zeros
// - Double: low word even register, high word odd register
// - Pixel operations always on a 64-bit word
// - 16-bit pixel fields 6,6,4; 32-bit pixel three 8s plus attribute
// - Pixel size 00=8, 01=16, 10=32, 11 undefined
// - Set mask bit, lowest first, enables its pixel store
`timescale 1ns/1ps
module ofu_top (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// Load path
	input  wire logic                  i_ld_valid,
	input  wire ofu_pkg::ofu_size_t    i_ld_size,
	input  wire logic [127:0]          i_ld_data,
	output logic                       o_ld_valid,
	output logic [127:0]               o_ld_data,
	// Store path
	input  wire logic                  i_st_valid,
	input  wire ofu_pkg::ofu_size_t    i_st_size,
	input  wire logic [127:0]          i_st_data,
	output logic                       o_st_valid,
	output logic [127:0]               o_st_data,
	output logic [15:0]                o_st_byte_en,
	// 64-bit integer add/sub
	input  wire logic                  i_ar_valid,
	input  wire logic                  i_ar_sub,
	input  wire logic [63:0]           i_ar_a,
	input  wire logic [63:0]           i_ar_b,
	output logic                       o_ar_valid,
	output logic [63:0]                o_ar_result,
	output logic                       o_ar_carry,
	output logic                       o_ar_overflow,
	// Floating-point operand check
	input  wire logic                  i_fp_valid,
	input  wire logic                  i_fp_dbl,
	input  wire logic [31:0]           i_fp_even_reg,
	input  wire logic [31:0]           i_fp_odd_reg,
	output logic                       o_fp_valid,
	output logic                       o_fp_src_exc,
	output logic                       o_fp_zero,
	output logic                       o_fp_sign,
	output logic [11:0]                o_fp_unb_exp,
	output logic [52:0]                o_fp_mant,
	// Floating-point result guard
	input  wire logic                  i_fr_valid,
	input  wire logic                  i_fr_dbl,
	input  wire logic [63:0]           i_fr_data,
	output logic                       o_fr_valid,
	output logic [31:0]                o_fr_even_reg,
	output logic [31:0]                o_fr_odd_reg,
	// Pixel store
	input  wire logic                  i_px_valid,
	input  wire logic [1:0]            i_pixel_size_field,
	input  wire logic [7:0]            i_pixel_write_mask,
	input  wire logic [63:0]           i_px_data,
	output logic                       o_px_valid,
	output logic [63:0]                o_px_data,
	output logic [7:0]                 o_px_byte_en,
	output logic                       o_px_size_bad,
	// Pixel field view of low pixel
	output logic [5:0]                 o_px16_f1,
	output logic [5:0]                 o_px16_f2,
	output logic [3:0]                 o_px16_f3,
	output logic [31:0]                o_px32_fields
);
	import ofu_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	// Sign extension
	function automatic logic [31:0] sext(input logic [15:0] v, input logic is8);
		if (is8) begin
			return {{24{v[7]}}, v[7:0]};
		end
		return {{16{v[15]}}, v};
	endfunction : sext

	function automatic logic [15:0] size_be(input ofu_size_t s);
		case (s)
			OFU_SZ_8:  return 16'h0001;
			OFU_SZ_16: return 16'h0003;
			OFU_SZ_32: return 16'h000f;
			OFU_SZ_64: return 16'h00ff;
			default:   return 16'hffff;
		endcase
	endfunction : size_be

	// ****************************************
	// Load path
	// ****************************************
	logic [127:0] ld_d;

	always_comb begin
		ld_d = i_ld_data;
		case (i_ld_size)
			OFU_SZ_8:  ld_d = {96'h0, sext(i_ld_data[15:0], 1'b1)};
			OFU_SZ_16: ld_d = {96'h0, sext(i_ld_data[15:0], 1'b0)};
			OFU_SZ_32: ld_d = {96'h0, i_ld_data[31:0]};
			OFU_SZ_64: ld_d = {64'h0, i_ld_data[63:0]};
			default:   ld_d = i_ld_data;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ld_valid <= 1'b0;
			o_ld_data  <= {RST_WORD, RST_WORD};
		end else begin
			o_ld_valid <= i_ld_valid;
			if (i_ld_valid) begin
				o_ld_data <= ld_d;
			end
		end
	end

	// ****************************************
	// Store path
	// ****************************************
	logic [15:0]  st_be;
	logic [127:0] st_d;

	always_comb begin
		st_be = size_be(i_st_size);
		for (int k = 0; k < 16; k++) begin
			st_d[8*k +: 8] = st_be[k] ? i_st_data[8*k +: 8] : 8'h00;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_st_valid   <= 1'b0;
			o_st_data    <= {RST_WORD, RST_WORD};
			o_st_byte_en <= 16'h0000;
		end else begin
			o_st_valid <= i_st_valid;
			if (i_st_valid) begin
				o_st_data    <= st_d;
				o_st_byte_en <= st_be;
			end
		end
	end

	// ****************************************
	// 64-bit add/sub
	// ****************************************
	logic [63:0] ar_b;
	logic [64:0] ar_sum;
	logic        ar_ovf;

	always_comb begin
		ar_b   = i_ar_sub ? ~i_ar_b : i_ar_b;
		ar_sum = {1'b0, i_ar_a} + {1'b0, ar_b} + {64'h0, i_ar_sub};
		ar_ovf = (i_ar_a[63] == ar_b[63]) && (ar_sum[63] != i_ar_a[63]);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ar_valid    <= 1'b0;
			o_ar_result   <= RST_WORD;
			o_ar_carry    <= 1'b0;
			o_ar_overflow <= 1'b0;
		end else begin
			o_ar_valid <= i_ar_valid;
			if (i_ar_valid) begin
				o_ar_result <= ar_sum[63:0];
				o_ar_carry    <= ar_sum[64] ^ i_ar_sub;
				o_ar_overflow <= ar_ovf;
			end
		end
	end

	// ****************************************
	// Operand classification
	// ****************************************
	logic [63:0] fp_op;
	logic        c_trap;
	logic        c_zero;
	logic        c_sign;
	logic [11:0] c_exp;
	logic [52:0] c_mant;

	assign fp_op = i_fp_dbl ? {i_fp_odd_reg, i_fp_even_reg} : {32'h0, i_fp_even_reg};

	ofu_fp_class u_class (
		.i_dbl     (i_fp_dbl),
		.i_op      (fp_op),
		.o_trap    (c_trap),
		.o_zero    (c_zero),
		.o_sign    (c_sign),
		.o_unb_exp (c_exp),
		.o_mant    (c_mant)
	);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fp_valid   <= 1'b0;
			o_fp_src_exc <= 1'b0;
			o_fp_zero    <= 1'b0;
			o_fp_sign    <= 1'b0;
			o_fp_unb_exp <= 12'h000;
			o_fp_mant    <= 53'h0_0000_0000_0000;
		end else begin
			o_fp_valid <= i_fp_valid;
			o_fp_src_exc <= i_fp_valid & c_trap;
			if (i_fp_valid) begin
				o_fp_zero    <= c_zero;
				o_fp_sign    <= c_sign;
				o_fp_unb_exp <= c_exp;
				o_fp_mant    <= c_mant;
			end
		end
	end

	// ****************************************
	// Result guard
	// ****************************************
	logic [63:0] fr_d;
	logic        fr_bad;

	always_comb begin
		fr_d = i_fr_data;
		if (i_fr_dbl) begin
			fr_bad = (i_fr_data[DBL_EXP_HI:DBL_EXP_LO] == DBL_EXP_MAX)
				| (i_fr_data[DBL_EXP_HI:DBL_EXP_LO] == 11'h000);
			if (fr_bad) begin
				fr_d = {i_fr_data[DBL_SIGN_POS], 63'h0};
			end
		end else begin
			fr_bad = (i_fr_data[SGL_EXP_HI:SGL_EXP_LO] == SGL_EXP_MAX)
				| (i_fr_data[SGL_EXP_HI:SGL_EXP_LO] == 8'h00);
			fr_d[63:32] = 32'h0000_0000;
			if (fr_bad) begin
				fr_d[31:0] = {i_fr_data[SGL_SIGN_POS], 31'h0};
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fr_valid    <= 1'b0;
			o_fr_even_reg <= 32'h0000_0000;
			o_fr_odd_reg  <= 32'h0000_0000;
		end else begin
			o_fr_valid <= i_fr_valid;
			if (i_fr_valid) begin
				o_fr_even_reg <= fr_d[PAIR_LO_HI:0];
				o_fr_odd_reg  <= fr_d[63:PAIR_HI_LO];
			end
		end
	end

	// ****************************************
	// Pixel store
	// ****************************************
	logic [7:0] px_be;
	logic       px_bad;

	ofu_pix_store u_pix (
		.i_pixel_size_field (i_pixel_size_field),
		.i_pixel_write_mask (i_pixel_write_mask),
		.o_byte_en          (px_be),
		.o_size_bad         (px_bad)
	);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_px_valid    <= 1'b0;
			o_px_data     <= RST_WORD;
			o_px_byte_en  <= 8'h00;
			o_px_size_bad <= 1'b0;
			o_px16_f1     <= 6'h00;
			o_px16_f2     <= 6'h00;
			o_px16_f3     <= 4'h0;
			o_px32_fields <= 32'h0000_0000;
		end else begin
			o_px_valid <= i_px_valid;
			if (i_px_valid) begin
				o_px_data     <= i_px_data;
				o_px_byte_en  <= px_be;
				o_px_size_bad <= px_bad;
				o_px16_f3     <= i_px_data[PIX16_F3_W-1:0];
				o_px16_f2     <= i_px_data[PIX16_F3_W +: PIX16_F2_W];
				o_px16_f1     <= i_px_data[PIX16_F3_W+PIX16_F2_W +: PIX16_F1_W];
				o_px32_fields <= i_px_data[4*PIX32_F_W-1:0];
			end
		end
	end

endmodule : ofu_top

// [testbench/ofu_chk.sv]
`timescale 1ns/1ps
module ofu_chk
	import ofu_pkg::*;
(
	input wire logic               i_clk,
	input wire logic               i_rst,
	input wire logic               i_ld_valid,
	input wire ofu_pkg::ofu_size_t i_ld_size,
	input wire logic [127:0]       i_ld_data,
	input wire logic               o_ld_valid,
	input wire logic [127:0]       o_ld_data,
	input wire logic               i_st_valid,
	input wire ofu_pkg::ofu_size_t i_st_size,
	input wire logic [127:0]       i_st_data,
	input wire logic [127:0]       o_st_data,
	input wire logic [15:0]        o_st_byte_en,
	input wire logic               i_ar_valid,
	input wire logic               i_ar_sub,
	input wire logic [63:0]        i_ar_a,
	input wire logic [63:0]        i_ar_b,
	input wire logic [63:0]        o_ar_result,
	input wire logic               i_fp_valid,
	input wire logic               i_fp_dbl,
	input wire logic [31:0]        i_fp_even_reg,
	input wire logic [31:0]        i_fp_odd_reg,
	input wire logic               o_fp_src_exc,
	input wire logic               o_fp_zero,
	input wire logic               o_fp_sign,
	input wire logic               i_fr_valid,
	input wire logic               i_fr_dbl,
	input wire logic [31:0]        o_fr_odd_reg,
	input wire logic               i_px_valid,
	input wire logic [1:0]         i_pixel_size_field,
	input wire logic [7:0]         i_pixel_write_mask,
	input wire logic [7:0]         o_px_byte_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	ld_sext_a: assert property (i_ld_valid && i_ld_size == OFU_SZ_8 |=> o_ld_valid
		&& o_ld_data == {96'h0, {24{$past(i_ld_data[7])}}, $past(i_ld_data[7:0])}) else $error("load sign extend");
	st_trunc_a: assert property (i_st_valid && i_st_size == OFU_SZ_16 |=> o_st_byte_en == 16'h0003
		&& o_st_data == {112'h0, $past(i_st_data[15:0])}) else $error("store truncate");
	ar_sum_a: assert property (i_ar_valid |=> o_ar_result == ($past(i_ar_sub) ?
		$past(i_ar_a) - $past(i_ar_b) : $past(i_ar_a) + $past(i_ar_b))) else $error("add sub result");
	fp_trap_a: assert property (i_fp_valid && (i_fp_dbl ? i_fp_odd_reg[30:20] == 11'h7ff
		: i_fp_even_reg[30:23] == 8'hff) |=> o_fp_src_exc) else $error("missing trap");
	exc_pulse_a: assert property (!i_fp_valid |=> !o_fp_src_exc) else $error("stray trap");
	fp_zero_a: assert property (i_fp_valid && !i_fp_dbl && i_fp_even_reg[30:0] == 31'h0
		|=> !o_fp_src_exc && o_fp_zero && o_fp_sign == $past(i_fp_even_reg[31])) else $error("signed zero");
	fr_noinf_a: assert property (i_fr_valid && i_fr_dbl |=> o_fr_odd_reg[30:20] != 11'h7ff)
		else $error("result not normal");
	px_mask_a: assert property (i_px_valid && i_pixel_size_field == 2'h0
		|=> o_px_byte_en == $past(i_pixel_write_mask)) else $error("pixel mask");
endmodule : ofu_chk

bind ofu_top ofu_chk i_ofu_chk (.*);

// [testbench/ofu_regpair.sv]
`timescale 1ns/1ps
module ofu_regpair (
	input  wire logic        i_clk,
	input  wire logic        i_wr,
	input  wire logic [31:0] i_even,
	input  wire logic [31:0] i_odd,
	output logic      [63:0] o_pair
);
	logic [31:0] even_q;
	logic [31:0] odd_q;
	always_ff @(posedge i_clk) begin
		if (i_wr) begin
			even_q <= i_even;
			odd_q  <= i_odd;
		end
	end
	assign o_pair = {odd_q, even_q};
endmodule : ofu_regpair

// [testbench/ofu_top_tb.sv]
`timescale 1ns/1ps
module ofu_top_tb;
	import ofu_pkg::*;
	logic i_clk = 0, i_rst = 1, i_ld_valid = 0, i_st_valid = 0, i_ar_valid = 0, i_ar_sub = 0, i_fp_valid = 0;
	logic i_fp_dbl = 0, i_fr_valid = 0, i_fr_dbl = 0, i_px_valid = 0;
	ofu_size_t i_ld_size = OFU_SZ_8, i_st_size = OFU_SZ_8;
	logic [127:0] i_ld_data = '0, i_st_data = '0, o_ld_data, o_st_data;
	logic [63:0] i_ar_a = '0, i_ar_b = '0, i_fr_data = '0, i_px_data = '0, o_ar_result, o_px_data, pair;
	logic [31:0] i_fp_even_reg = '0, i_fp_odd_reg = '0, o_fr_even_reg, o_fr_odd_reg, o_px32_fields;
	logic [1:0] i_pixel_size_field = '0;
	logic [7:0] i_pixel_write_mask = '0, o_px_byte_en;
	logic o_ld_valid, o_st_valid, o_ar_valid, o_ar_carry, o_ar_overflow, o_fp_valid, o_fp_src_exc, o_fp_zero;
	logic o_fp_sign, o_fr_valid, o_px_valid, o_px_size_bad, zr, sg;
	logic [15:0] o_st_byte_en;
	logic [11:0] o_fp_unb_exp, ue;
	logic [52:0] o_fp_mant, m;
	logic [5:0] o_px16_f1, o_px16_f2;
	logic [3:0] o_px16_f3;
	logic [65:0] r;
	int fail_count = 0, comparisons = 0;
	// Rows: trap flag, double flag, odd word, even word
	logic [65:0] rows [13] = '{66'h0_0000_0000_3f80_0000, 66'h0_0000_0000_c020_0000, 66'h0_0000_0000_0080_0000,
		66'h0_0000_0000_8000_0000, 66'h2_0000_0000_7f80_0000, 66'h2_0000_0000_ffc0_0000, 66'h2_0000_0000_0000_0001,
		66'h1_3ff0_0000_0000_0000, 66'h1_7fef_ffff_ffff_ffff, 66'h1_8000_0000_0000_0000, 66'h3_7ff0_0000_0000_0000,
		66'h3_0000_0000_0000_0001, 66'h0_7ff0_0000_3f80_0000};
	logic [7:0] pen [4] = '{8'ha5, 8'h33, 8'h0f, 8'h00};

	ofu_top i_ofu_top (.*);
	ofu_regpair i_ofu_regpair (.i_clk(i_clk), .i_wr(o_fr_valid), .i_even(o_fr_even_reg), .i_odd(o_fr_odd_reg),
		.o_pair(pair));

	always #5 i_clk = ~i_clk;

	task automatic chk(input logic c, input string msg);
		comparisons++;
		if (!c) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk

	task automatic test_done();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (500) @(posedge i_clk);
		fail_count++;
		test_done();
	end

	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 0;
		foreach (rows[k]) begin
			@(posedge i_clk);
			i_fp_valid <= 1;
			{i_fp_dbl, i_fp_odd_reg, i_fp_even_reg} <= rows[k][64:0];
			@(posedge i_clk);
			#1;
			r = rows[k];
			sg = r[64] ? r[63] : r[31];
			zr = r[64] ? r[62:0] == 63'h0 : r[30:0] == 31'h0;
			ue = r[64] ? {1'b0, r[62:52]} - 12'h3ff : {4'h0, r[30:23]} - 12'h07f;
			m = r[64] ? {1'b1, r[51:0]} : {1'b1, r[22:0], 29'h0};
			chk(o_fp_valid === 1'b1 && o_fp_src_exc === r[65], "fp trap flag");
			if (!r[65]) chk(o_fp_zero === zr && o_fp_sign === sg, "fp zero sign");
			if (!r[65] && !zr) chk(o_fp_unb_exp === ue && o_fp_mant === m, "fp value");
		end
		$display("test fp table done");
		@(posedge i_clk);
		{i_fp_valid, i_ld_valid, i_st_valid, i_ar_valid, i_fr_valid, i_fr_dbl} <= 6'h3f;
		i_ld_size <= OFU_SZ_8;
		{i_ld_data, i_st_data} <= {120'h0, 8'h80, 112'h0, 16'h12f0};
		{i_ar_sub, i_ar_a, i_ar_b} <= {1'b0, 64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0001};
		i_fr_data <= 64'h3ff8_0000_0000_0001;
		@(posedge i_clk);
		#1;
		chk(o_ld_valid === 1'b1 && o_ld_data === {96'h0, 32'hffff_ff80}, "load byte");
		chk(o_st_byte_en === 16'h0001 && o_st_data === {120'h0, 8'hf0}, "store byte");
		chk(o_ar_result === 64'h0 && o_ar_carry === 1'b1 && o_ar_overflow === 1'b0, "add wrap");
		chk(o_fr_odd_reg === 32'h3ff8_0000 && o_fr_even_reg === 32'h0000_0001, "pair split");
		chk(o_st_valid === 1'b1 && o_ar_valid === 1'b1 && o_fr_valid === 1'b1, "result valid");
		@(posedge i_clk);
		i_ld_size <= OFU_SZ_16;
		i_st_size <= OFU_SZ_128;
		{i_ld_data, i_st_data} <= {112'h0, 16'h7fff, ~128'h0};
		{i_ar_sub, i_ar_a, i_ar_b} <= {1'b1, 64'h8000_0000_0000_0000, 64'h0000_0000_0000_0001};
		i_fr_data <= 64'hfff0_0000_0000_0000;
		@(posedge i_clk);
		#1;
		chk(o_ld_data === {96'h0, 32'h0000_7fff}, "load half");
		chk(o_st_byte_en === 16'hffff && o_st_data === ~128'h0, "store wide");
		chk(o_ar_result === 64'h7fff_ffff_ffff_ffff && o_ar_overflow === 1'b1, "sub overflow");
		chk(o_ar_carry === 1'b0, "sub no borrow");
		chk(o_fr_odd_reg === 32'h8000_0000 && o_fr_even_reg === 32'h0, "flush to zero");
		chk(pair === 64'h3ff8_0000_0000_0001, "pair rejoin");
		@(posedge i_clk);
		i_ld_size <= OFU_SZ_32;
		i_st_size <= OFU_SZ_16;
		{i_ld_data, i_st_data} <= {4{64'h8123_4567_89ab_cdef}};
		{i_ar_sub, i_ar_a, i_ar_b} <= {1'b1, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0002};
		{i_fr_dbl, i_fr_data} <= {1'b0, 64'h1234_5678_c040_0000};
		@(posedge i_clk);
		#1;
		chk(o_ld_data === {96'h0, 32'h89ab_cdef}, "load word");
		chk(o_st_byte_en === 16'h0003 && o_st_data === {112'h0, 16'hcdef}, "store half");
		chk(o_ar_result === 64'hffff_ffff_ffff_ffff && o_ar_carry === 1'b1, "sub borrow");
		chk(o_fr_even_reg === 32'hc040_0000 && o_fr_odd_reg === 32'h0, "single result");
		@(posedge i_clk);
		i_ld_size <= OFU_SZ_64;
		i_st_size <= OFU_SZ_32;
		i_fr_data <= 64'h0000_0000_ff80_0000;
		@(posedge i_clk);
		#1;
		chk(o_ld_data === {64'h0, 64'h8123_4567_89ab_cdef}, "load double");
		chk(o_st_byte_en === 16'h000f && o_st_data === {96'h0, 32'h89ab_cdef}, "store word");
		chk(o_fr_even_reg === 32'h8000_0000 && o_fr_odd_reg === 32'h0, "single flush");
		@(posedge i_clk);
		i_ld_size <= OFU_SZ_128;
		i_st_size <= OFU_SZ_64;
		@(posedge i_clk);
		#1;
		chk(o_ld_data === {2{64'h8123_4567_89ab_cdef}}, "load quad");
		chk(o_st_byte_en === 16'h00ff && o_st_data === {64'h0, 64'h8123_4567_89ab_cdef}, "store double");
		$display("test load store done");
		@(posedge i_clk);
		{i_fp_valid, i_ld_valid, i_st_valid, i_ar_valid, i_fr_valid} <= 5'h0;
		for (int c = 0; c < 4; c++) begin
			@(posedge i_clk);
			{i_px_valid, i_pixel_size_field, i_pixel_write_mask} <= {1'b1, c[1:0], 8'ha5};
			i_px_data <= 64'hfedc_ba98_7654_3210;
			@(posedge i_clk);
			#1;
			chk(o_px_byte_en === pen[c] && o_px_size_bad === (c == 3), "pixel mask");
			chk(o_px_valid === 1'b1, "pixel valid");
			chk(o_px_data === 64'hfedc_ba98_7654_3210 && o_px32_fields === 32'h7654_3210, "pixel word");
			chk(o_px16_f1 === 6'h0c && o_px16_f2 === 6'h21 && o_px16_f3 === 4'h0, "pixel fields");
		end
		chk(o_ld_valid === 1'b0 && o_fp_valid === 1'b0 && o_fp_src_exc === 1'b0, "valid drops");
		$display("test pixel done");
		@(posedge i_clk);
		i_rst <= 1;
		@(posedge i_clk);
		#1;
		chk(o_px_data === 64'h0 && o_ld_data === 128'h0 && o_fp_valid === 1'b0, "reset clears");
		$display("test reset done");
		test_done();
	end
endmodule : ofu_top_tb
